//--- verilog/srd_decoder.sv
`timescale 1ns/10ps
// Behaviour
// [R1] only service type 20 is accepted
// [R2] subtype 1 sets low-rate science flag
// [R3] subtype 2 clears low-rate science flag
// [R4] subtype 10 sets high-speed science flag
// [R5] low 7 identifier bits match science id
// [R6] sender increments 12-bit sequence counter
// [R7] CRC16 verified before any action
// [R8] data field is exactly eight bytes
// [R9] packet must be fourteen bytes total
// [R10] subtype 11 clears high-speed science flag
// [R11] bad packets leave both flags unchanged
// [R12] both flags cleared after reset
module srd_decoder
  #(parameter int BYTE_CNT_W = 5)
  (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // telecommand byte stream, last marks the final byte
  input  wire srd_pkg::srd_byte_type  tc_in,
  // science reporting enables
  output      logic                   science_low_rate_en,
  output      logic                   science_high_speed_en,
  // verdict of the last packet, done is one pulse
  output      srd_pkg::srd_status_type status
  );
  import srd_pkg::*;

  initial
  begin
    if ((1 << BYTE_CNT_W) <= PKT_LEN)
      $error("byte counter too narrow");
  end

  typedef enum logic [1:0] {
    ST_RECV = 2'b01,
    ST_DROP = 2'b10
  } srd_state_type;

  ////////////////////////////////////////////////////////////////////////////
  srd_state_type           state;
  srd_state_type           next_state;
  logic [BYTE_CNT_W-1:0]   count;
  logic [7:0]              hdr [0:DF_LEN-3];
  logic [15:0]             crc;

  wire [BYTE_CNT_W-1:0] df_idx  = count - BYTE_CNT_W'(PRI_HDR_LEN);
  wire                  in_df   = count >= BYTE_CNT_W'(PRI_HDR_LEN);
  wire                  store   = tc_in.valid && in_df && df_idx < BYTE_CNT_W'(DF_LEN - 2);
  wire                  end_pkt = tc_in.valid && tc_in.last;
  // over-long packets go to drop until their last byte
  wire                  overrun = tc_in.valid && !tc_in.last
                                  && count == BYTE_CNT_W'(PKT_LEN - 1);

  srd_crc16 #(.POLY(CRC_POLY), .INIT(CRC_INIT)) u_crc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clear   (end_pkt || state == ST_DROP),
    .enable  (tc_in.valid && state == ST_RECV),
    .data    (tc_in.data),
    .crc     (crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks, evaluated on the final byte
  // [R9] exact total length
  wire len_ok  = count == BYTE_CNT_W'(PKT_LEN - 1) && state == ST_RECV;
  // [R1] service type field
  wire svc_ok  = hdr[0] == HDR_BYTE0 && hdr[1] == SERVICE_TYPE && hdr[3] == HDR_BYTE3;
  // [R5] identifier in low bits
  wire pid_ok  = hdr[5][PID_BITS-1:0] == SCIENCE_PID;
  // [R7] residue over packet plus crc is zero with this crc form
  logic [15:0] crc_fin;
  always_comb
  begin
    crc_fin = crc;
    for (int i = 7; i >= 0; i--)
    begin
      if (crc_fin[15] ^ tc_in.data[i])
        crc_fin = {crc_fin[14:0], 1'b0} ^ CRC_POLY;
      else
        crc_fin = {crc_fin[14:0], 1'b0};
    end
  end
  wire crc_good = crc_fin == 16'h0000;

  wire [7:0] sub = hdr[2];
  wire sub_known = sub == SUB_LR_ENABLE || sub == SUB_LR_DISABLE
                   || sub == SUB_HS_ENABLE || sub == SUB_HS_DISABLE;
  // [R8] data field byte count enforced through len_ok
  // [R11] act only when every check passes
  wire accept = end_pkt && len_ok && svc_ok && pid_ok && crc_good && sub_known;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RECV: if (overrun) next_state = ST_DROP;
      ST_DROP: if (end_pkt) next_state = ST_RECV;
      default: next_state = ST_RECV;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state <= ST_RECV;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      if (end_pkt)
        count <= '0;
      else if (tc_in.valid && state == ST_RECV && !overrun)
        count <= count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (store && state == ST_RECV)
      hdr[df_idx[2:0]] <= tc_in.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk)
  begin
    // [R12] flags start cleared
    if (!rstn)
    begin
      science_low_rate_en   <= FLAG_RESET;
      science_high_speed_en <= FLAG_RESET;
    end
    else if (accept)
    begin
      // [R2] low-rate enable
      if (sub == SUB_LR_ENABLE)
        science_low_rate_en <= 1'b1;
      // [R3] low-rate disable
      if (sub == SUB_LR_DISABLE)
        science_low_rate_en <= 1'b0;
      // [R4] high-speed enable
      if (sub == SUB_HS_ENABLE)
        science_high_speed_en <= 1'b1;
      // [R10] high-speed disable
      if (sub == SUB_HS_DISABLE)
        science_high_speed_en <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      status <= '0;
    else
    begin
      status.done <= end_pkt;
      if (end_pkt)
      begin
        status.accepted <= accept;
        status.crc_bad  <= !crc_good;
        status.len_bad  <= !len_ok;
        status.hdr_bad  <= !(svc_ok && sub_known);
        status.pid_bad  <= !pid_ok;
      end
    end
  end

endmodule

//--- shared/srd_pkg.sv
package srd_pkg;

  // byte stream carrier
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } srd_byte_type;

  // per-packet verdict
  typedef struct packed {
    logic done;
    logic accepted;
    logic crc_bad;
    logic len_bad;
    logic hdr_bad;
    logic pid_bad;
  } srd_status_type;

  localparam int         PKT_LEN        = 14;
  localparam int         PRI_HDR_LEN    = 6;
  localparam int         DF_LEN         = 8;
  localparam logic [7:0] HDR_BYTE0      = 8'h11;
  localparam logic [7:0] SERVICE_TYPE   = 8'h14;
  localparam logic [7:0] HDR_BYTE3      = 8'h00;
  localparam logic [7:0] SUB_LR_ENABLE  = 8'h01;
  localparam logic [7:0] SUB_LR_DISABLE = 8'h02;
  localparam logic [7:0] SUB_HS_ENABLE  = 8'h0A;
  localparam logic [7:0] SUB_HS_DISABLE = 8'h0B;
  localparam logic [6:0] SCIENCE_PID    = 7'h51;
  localparam int         PID_BITS       = 7;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic       FLAG_RESET     = 1'b0;

endpackage

//--- verilog/srd_crc16.sv
`timescale 1ns/10ps
module srd_crc16
  #(parameter logic [15:0] POLY = 16'h1021,
    parameter logic [15:0] INIT = 16'hFFFF)
  (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // control
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  data,
  // result
  output      logic [15:0] crc
  );

  logic [15:0] next_crc;

  always_comb
  begin
    next_crc = crc;
    for (int i = 7; i >= 0; i--)
    begin
      if (next_crc[15] ^ data[i])
        next_crc = {next_crc[14:0], 1'b0} ^ POLY;
      else
        next_crc = {next_crc[14:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn || clear)
      crc <= INIT;
    else if (enable)
      crc <= next_crc;
  end

endmodule

//--- tb/srd_assertions.sv
`timescale 1ns/10ps
module srd_checker
  (
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire srd_pkg::srd_byte_type   tc_in,
  input wire logic                    science_low_rate_en,
  input wire logic                    science_high_speed_en,
  input wire srd_pkg::srd_status_type status
  );
  import srd_pkg::*;
  wire [1:0] en = {science_low_rate_en, science_high_speed_en};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence pkt_end; tc_in.valid && tc_in.last; endsequence
  sequence verdict; status.done; endsequence
  end_gives_verdict_a:
    assert property (pkt_end |=> verdict) else $error("no verdict after last byte");
  verdict_needs_end_a:
    assert property (verdict |-> $past(tc_in.last) && $past(tc_in.valid))
    else $error("verdict without last byte");
  flags_quiet_a:
    assert property (!status.done |-> $stable(en)) else $error("flag moved without verdict");
  reject_keeps_a:
    assert property (status.done && !status.accepted |-> $stable(en))
    else $error("refused packet moved a flag");
  crc_refuses_a:
    assert property (status.crc_bad |-> !status.accepted) else $error("bad crc accepted");
  low_rise_a:
    assert property ($rose(en[1]) |-> status.accepted) else $error("low-rate set unaccepted");
  high_fall_a:
    assert property ($fell(en[0]) |-> status.accepted) else $error("high-speed cleared unaccepted");
  reset_clear_a:
    assert property (disable iff (1'b0) !rstn |=> en == 2'b00 && status == '0)
    else $error("reset left state set");
endmodule

//--- tb/srd_sender.sv
`timescale 1ns/10ps
module srd_sender
  (
  input  wire logic           ref_clk,
  output srd_pkg::srd_byte_type tc
  );
  import srd_pkg::*;
  logic [11:0] seq = 12'h000;
  initial tc = '0;
  function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = (c << 1) ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic send(input logic [7:0] s, b, d, input int n, input logic bad);
    logic [7:0]  p [16];
    logic [15:0] c;
    p = '{8'h1D, 8'h1C, {4'hC, seq[11:8]}, seq[7:0], 8'h00, 8'h07, HDR_BYTE0, s, b,
          HDR_BYTE3, 8'h00, d, 8'h00, 8'h00, 8'hA5, 8'h5A};
    c = CRC_INIT;
    for (int i = 0; i < 12; i++)
      c = crc(c, p[i]);
    {p[12], p[13]} = c ^ {15'h0000, bad};
    seq = seq + 12'h001;
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk) #1;
      tc = '{1'b1, i == n - 1, p[i]};
    end
    @(posedge ref_clk) #1;
    tc = '{1'b0, 1'b0, ~tc.data};
  endtask
endmodule

//--- tb/science_report_enable_decoder_tb.sv
`timescale 1ns/10ps
module science_report_enable_decoder_tb;
  import srd_pkg::*;
  logic           ref_clk = 1'b0;
  logic           rstn = 1'b0;
  srd_byte_type   tc_in;
  logic           lr_en;
  logic           hs_en;
  srd_status_type status;
  int             fail_count = 0;
  int             n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  srd_sender u_srd_sender (.ref_clk(ref_clk), .tc(tc_in));
  srd_decoder u_srd_decoder (.ref_clk(ref_clk), .rstn(rstn), .tc_in(tc_in),
    .science_low_rate_en(lr_en), .science_high_speed_en(hs_en), .status(status));
  task automatic check(input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // e and m: done accepted crc len hdr pid low high
  task automatic cmd(input logic [7:0] s, b, d, input int n, input logic c,
                     input logic [7:0] e, input logic [7:0] m = 8'hFF);
    u_srd_sender.send(s, b, d, n, c);
    // done stands only in the cycle after the last byte, so judge right here
    check({status, lr_en, hs_en} & m, e);
  endtask
  task automatic do_reset();
    @(posedge ref_clk) #1;
    rstn = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    check({status, lr_en, hs_en}, 8'h00);
  endtask
  task automatic t_enable();
    cmd(8'h14, 8'h01, 8'h51, 14, 1'b0, 8'hC2);
    cmd(8'h14, 8'h0A, 8'hD1, 14, 1'b0, 8'hC3);
    $display("enable test done");
  endtask
  // crc is not judged on wrong lengths
  task automatic t_reject();
    cmd(8'h14, 8'h02, 8'h51, 14, 1'b1, 8'hA3);
    cmd(8'h14, 8'h02, 8'h51, 13, 1'b0, 8'h93, 8'hDF);
    cmd(8'h14, 8'h02, 8'h51, 15, 1'b0, 8'h93, 8'hDF);
    cmd(8'h15, 8'h02, 8'h51, 14, 1'b0, 8'h8B);
    cmd(8'h14, 8'h03, 8'h51, 14, 1'b0, 8'h8B);
    cmd(8'h14, 8'h0B, 8'h52, 14, 1'b0, 8'h87);
    $display("reject test done");
  endtask
  task automatic t_disable();
    cmd(8'h14, 8'h02, 8'h51, 14, 1'b0, 8'hC1);
    cmd(8'h14, 8'h0B, 8'h51, 14, 1'b0, 8'hC0);
    $display("disable test done");
  endtask
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_enable();
    t_reject();
    t_disable();
    cmd(8'h14, 8'h0A, 8'h51, 14, 1'b0, 8'hC1);
    do_reset();
    $display("reset test done");
    conclude();
  end
  initial
  begin
    #5000;
    fail_count++;
    conclude();
  end
endmodule
bind srd_decoder srd_checker u_srd_checker (.ref_clk(ref_clk), .rstn(rstn), .tc_in(tc_in),
  .science_low_rate_en(science_low_rate_en), .science_high_speed_en(science_high_speed_en),
  .status(status));
